// ---- core/rtcsl_consts.svh ----
// shared constants of the rtc serial access port
`ifndef RTCSL_CONSTS_SVH
`define RTCSL_CONSTS_SVH

`define RTCSL_SLAVE_ADDR     8'hD0
`define RTCSL_NUM_BYTES      4'h8
`define RTCSL_CAL_ADDR       3'h7
`define RTCSL_LAST_CLK_ADDR  3'h6
`define RTCSL_BYTE_BITS      4'h8
`define RTCSL_ACK_BIT        4'h9
`define RTCSL_CLK_FREQ_HZ    250000000
`define RTCSL_SCL_FREQ_HZ    400000
`define RTCSL_SCL_QTR_CYCLES \
	((`RTCSL_CLK_FREQ_HZ + 4 * `RTCSL_SCL_FREQ_HZ - 1) / (4 * `RTCSL_SCL_FREQ_HZ))
`define RTCSL_QTR_W          8
`define RTCSL_REC_TIME_NS    1000
`define RTCSL_CLK_PERIOD_NS  4
`define RTCSL_REC_CYCLES \
	((`RTCSL_REC_TIME_NS + `RTCSL_CLK_PERIOD_NS - 1) / `RTCSL_CLK_PERIOD_NS)
`define RTCSL_REC_W          12

`endif

// ---- core/rtcsl_pkg.sv ----
// types shared by both ends of the rtc serial access port
package rtcsl_pkg;
	typedef enum logic [4:0] {
		RTCSL_D_IDLE  = 5'h01,
		RTCSL_D_ADDR  = 5'h02,
		RTCSL_D_WORD  = 5'h04,
		RTCSL_D_WRITE = 5'h08,
		RTCSL_D_READ  = 5'h10
	} rtcsl_dev_state_t;

	typedef enum logic [3:0] {
		RTCSL_M_IDLE  = 4'h1,
		RTCSL_M_START = 4'h2,
		RTCSL_M_STOP  = 4'h4,
		RTCSL_M_BYTE  = 4'h8
	} rtcsl_mst_state_t;

	typedef enum logic [1:0] {
		RTCSL_OP_START = 2'h0,
		RTCSL_OP_STOP  = 2'h1,
		RTCSL_OP_WRITE = 2'h2,
		RTCSL_OP_READ  = 2'h3
	} rtcsl_op_t;
endpackage : rtcsl_pkg

// ---- core/rtcsl_if.sv ----
// two-wire link between bus master and rtc access port
`timescale 1ns/1ps
interface rtcsl_if;
	logic scl_o;     // master scl level when driving
	logic scl_oe;    // master pulls scl
	logic sda_m_o;   // master sda level when driving
	logic sda_m_oe;  // master drives sda
	logic sda_s_o;   // device sda level when driving
	logic sda_s_oe;  // device drives sda
	logic scl_line;  // resolved scl wire
	logic sda_line;  // resolved sda wire

	// open-drain wires with pull-ups: only a driven low wins
	assign scl_line = !(scl_oe && !scl_o);
	assign sda_line = !((sda_m_oe && !sda_m_o) || (sda_s_oe && !sda_s_o));

	modport device (input scl_line, input sda_line, output sda_s_o, output sda_s_oe);
	modport master (input scl_line, input sda_line, output scl_o, output scl_oe,
		output sda_m_o, output sda_m_oe);
endinterface : rtcsl_if

// ---- core/rtcsl_sync.sv ----
// two-flop synchroniser for pin inputs
`timescale 1ns/1ps
module rtcsl_sync #(
	parameter int         W    = 1,
	parameter logic [W-1:0] INIT = '0
) (
	input  wire logic         sys_clk, // system clock
	input  wire logic         reset_n, // async reset, low
	input  wire logic [W-1:0] d,       // asynchronous inputs
	output logic      [W-1:0] q        // synchronised outputs
);
	logic [W-1:0] meta;

	// first stage feeds only the second stage
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			meta <= INIT;
			q    <= INIT;
		end
		else
		begin
			meta <= d;
			q    <= meta;
		end
	end
endmodule : rtcsl_sync

// ---- core/rtcsl_device.sv ----
// rtc serial access port: slave end with pointer, byte store and power gating
`timescale 1ns/1ps
`include "rtcsl_consts.svh"
module rtcsl_device (
	input  wire logic        sys_clk,       // system clock, 250 MHz
	input  wire logic        reset_n,       // async reset, low
	rtcsl_if.device          bus,           // two-wire link
	input  wire logic        power_fail,    // supply below threshold, async
	input  wire logic        tick_valid,    // counters hold a new value
	input  wire logic [55:0] tick_counts,   // internal counters, byte 0 seconds
	output logic             copy_frozen,   // counter copy suspended
	output logic             wr_strobe,     // one byte stored
	output logic       [2:0] wr_addr,       // address of stored byte
	output logic       [7:0] wr_data,       // stored byte
	output logic             divider_reset, // restart divider chain
	output logic             write_protect, // bus blocked
	output logic       [7:0] cal_value      // calibration byte
);
	logic [2:0]                    sync_q;
	logic                          scl;
	logic                          sda;
	logic                          pf;
	logic                          scl_prev;
	logic                          sda_prev;
	logic [`RTCSL_REC_W-1:0]       rec_cnt;
	rtcsl_pkg::rtcsl_dev_state_t   state;
	logic [3:0]                    bit_cnt;
	logic [7:0]                    shreg;
	logic [7:0]                    tx;
	logic [2:0]                    ptr;
	logic                          rw;
	logic                          ack_ok;
	logic                          sda_oe;
	logic [7:0]                    regs [0:7];

	rtcsl_sync #(
		.W    (3),
		.INIT (3'h7)
	) u_sync (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.d       ({power_fail, bus.scl_line, bus.sda_line}),
		.q       (sync_q)
	);

	// line conditions from synchronised samples
	wire blocked    = pf || (rec_cnt != '0);
	wire start_cond = scl && scl_prev && sda_prev && !sda;
	wire stop_cond  = scl && scl_prev && !sda_prev && sda;
	wire scl_rise   = scl && !scl_prev;
	wire scl_fall   = !scl && scl_prev;
	wire active     = (state != rtcsl_pkg::RTCSL_D_IDLE);
	wire fall_byte  = active && scl_fall && (bit_cnt == `RTCSL_BYTE_BITS);
	wire fall_ack   = active && scl_fall && (bit_cnt == `RTCSL_ACK_BIT);
	wire [7:0] own_addr = `RTCSL_SLAVE_ADDR;
	wire addr_match = (shreg[7:1] == own_addr[7:1]);
	wire [2:0] ptr_next = ptr + 3'h1;
	wire [7:0] rd_byte  = regs[ptr];
	wire [7:0] rd_next  = regs[ptr_next];
	wire wr_event   = fall_ack && (state == rtcsl_pkg::RTCSL_D_WRITE);
	wire freeze_now = active && (ptr <= `RTCSL_LAST_CLK_ADDR);

	assign scl = sync_q[1];
	assign sda = sync_q[0];
	assign pf  = sync_q[2];
	assign bus.sda_s_o  = 1'b0;
	assign bus.sda_s_oe = sda_oe;

	// previous samples for edge and condition detection
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			scl_prev <= 1'b1;
			sda_prev <= 1'b1;
		end
		else
		begin
			scl_prev <= scl;
			sda_prev <= sda;
		end
	end

	// recovery hold: reset starts protected so a cold start waits too
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			rec_cnt <= `RTCSL_REC_W'(`RTCSL_REC_CYCLES);
		else if (pf)
			rec_cnt <= `RTCSL_REC_W'(`RTCSL_REC_CYCLES);
		else if (rec_cnt != '0)
			rec_cnt <= rec_cnt - `RTCSL_REC_W'(1);
	end

	// receive shift and acknowledge sample on scl rise
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			shreg  <= 8'h00;
			ack_ok <= 1'b0;
		end
		else if (active && !blocked && scl_rise)
		begin
			if (bit_cnt < `RTCSL_BYTE_BITS)
				shreg <= {shreg[6:0], sda};
			else
				ack_ok <= !sda;
		end
	end

	// protocol state machine, drives sda on scl falls so it moves while low; blocked, start and stop release it at once
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state   <= rtcsl_pkg::RTCSL_D_IDLE;
			bit_cnt <= 4'h0;
			tx      <= 8'h00;
			ptr     <= 3'h0;
			rw      <= 1'b0;
			sda_oe  <= 1'b0;
		end
		else if (blocked)
		begin
			state   <= rtcsl_pkg::RTCSL_D_IDLE;
			ptr     <= 3'h0;
			bit_cnt <= 4'h0;
			sda_oe  <= 1'b0;
		end
		else if (start_cond)
		begin
			state   <= rtcsl_pkg::RTCSL_D_ADDR;
			bit_cnt <= 4'h0;
			sda_oe  <= 1'b0;
		end
		else if (stop_cond)
		begin
			state  <= rtcsl_pkg::RTCSL_D_IDLE;
			sda_oe <= 1'b0;
		end
		else if (active && scl_rise)
			bit_cnt <= bit_cnt + 4'h1;
		else if (fall_byte)
		begin
			unique case (state)
				rtcsl_pkg::RTCSL_D_ADDR:
					if (addr_match)
					begin
						sda_oe <= 1'b1;
						rw     <= shreg[0];
					end
					else
						state <= rtcsl_pkg::RTCSL_D_IDLE;
				rtcsl_pkg::RTCSL_D_WORD:  sda_oe <= 1'b1;
				rtcsl_pkg::RTCSL_D_WRITE: sda_oe <= 1'b1;
				rtcsl_pkg::RTCSL_D_READ:  sda_oe <= 1'b0; // release for master ack
				rtcsl_pkg::RTCSL_D_IDLE:  sda_oe <= 1'b0;
			endcase
		end
		else if (fall_ack)
		begin
			bit_cnt <= 4'h0;
			sda_oe  <= 1'b0;
			unique case (state)
				rtcsl_pkg::RTCSL_D_ADDR:
					if (rw)
					begin
						state  <= rtcsl_pkg::RTCSL_D_READ;
						tx     <= rd_byte;
						sda_oe <= !rd_byte[7];
					end
					else
						state <= rtcsl_pkg::RTCSL_D_WORD;
				rtcsl_pkg::RTCSL_D_WORD:
				begin
					ptr   <= shreg[2:0];
					state <= rtcsl_pkg::RTCSL_D_WRITE;
				end
				rtcsl_pkg::RTCSL_D_WRITE: ptr <= ptr_next;
				rtcsl_pkg::RTCSL_D_READ:
				begin
					ptr <= ptr_next;
					if (ack_ok)
					begin
						tx     <= rd_next;
						sda_oe <= !rd_next[7];
					end
					else
						state <= rtcsl_pkg::RTCSL_D_IDLE;
				end
				rtcsl_pkg::RTCSL_D_IDLE: ptr <= ptr;
			endcase
		end
		else if (active && scl_fall && (state == rtcsl_pkg::RTCSL_D_READ))
		begin
			tx     <= {tx[6:0], 1'b0};
			sda_oe <= !tx[6];
		end
	end

	// byte store: bus write beats a counter copy in the same cycle
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < 8; i++)
				regs[i] <= 8'h00;
		end
		else
		begin
			if (tick_valid && !freeze_now)
				for (int i = 0; i < 7; i++)
					regs[i] <= tick_counts[i*8 +: 8];
			if (wr_event)
				regs[ptr] <= shreg;
		end
	end

	// registered outputs toward timekeeping logic
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			copy_frozen   <= 1'b0;
			wr_strobe     <= 1'b0;
			wr_addr       <= 3'h0;
			wr_data       <= 8'h00;
			divider_reset <= 1'b0;
			write_protect <= 1'b1;
			cal_value     <= 8'h00;
		end
		else
		begin
			copy_frozen   <= freeze_now;
			wr_strobe     <= wr_event;
			wr_addr       <= ptr;
			wr_data       <= shreg;
			divider_reset <= wr_event && (ptr != `RTCSL_CAL_ADDR);
			write_protect <= blocked;
			cal_value     <= regs[`RTCSL_CAL_ADDR];
		end
	end
endmodule : rtcsl_device

// ---- core/rtcsl_master.sv ----
// two-wire bus master end: start, stop, byte write and byte read
`timescale 1ns/1ps
`include "rtcsl_consts.svh"
module rtcsl_master (
	input  wire logic                 sys_clk,  // system clock, 250 MHz
	input  wire logic                 reset_n,  // async reset, low
	rtcsl_if.master                   bus,      // two-wire link
	input  wire logic                 op_valid, // operation request
	input  wire rtcsl_pkg::rtcsl_op_t op_code,  // start, stop, write, read
	input  wire logic           [7:0] op_data,  // byte to send
	input  wire logic                 op_nack,  // read: leave byte unacknowledged
	output logic                      op_ready, // idle, may take an operation
	output logic                      done,     // operation finished, pulse
	output logic                [7:0] rd_data,  // byte on the wire
	output logic                      ack_seen  // ninth bit was low
);
	rtcsl_pkg::rtcsl_mst_state_t state;
	logic [`RTCSL_QTR_W-1:0]     qcnt;
	logic [1:0]                  q;
	logic [3:0]                  bidx;
	logic [7:0]                  sh;
	logic                        is_rd;
	logic                        nack_r;
	logic                        sda_in;
	logic                        scl_oe;
	logic                        sda_oe;

	rtcsl_sync #(
		.W    (1),
		.INIT (1'h1)
	) u_sync (
		.sys_clk (sys_clk),
		.reset_n (reset_n),
		.d       (bus.sda_line),
		.q       (sda_in)
	);

	// quarter-bit enable; rounded up so scl never beats its top rate
	wire tick    = (qcnt == `RTCSL_QTR_W'(`RTCSL_SCL_QTR_CYCLES - 1));
	wire is_ack  = (bidx == `RTCSL_BYTE_BITS);
	wire bit_out = is_ack ? (is_rd ? nack_r : 1'b1) : (is_rd ? 1'b1 : sh[7]);
	wire accept  = op_ready && op_valid;
	wire last_q  = tick && (q == 2'h3);

	assign bus.scl_o    = 1'b0;
	assign bus.scl_oe   = scl_oe;
	assign bus.sda_m_o  = 1'b0;
	assign bus.sda_m_oe = sda_oe;

	// divider runs only during an operation so phases start aligned
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
			qcnt <= '0;
		else if (state == rtcsl_pkg::RTCSL_M_IDLE || tick)
			qcnt <= '0;
		else
			qcnt <= qcnt + `RTCSL_QTR_W'(1);
	end

	// sequencer: each bit is four quarters; a byte moves sda in quarter 0 with scl low, start and stop move it in quarter 2 with scl high
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state    <= rtcsl_pkg::RTCSL_M_IDLE;
			q        <= 2'h0;
			bidx     <= 4'h0;
			sh       <= 8'h00;
			is_rd    <= 1'b0;
			nack_r   <= 1'b0;
			scl_oe   <= 1'b0;
			sda_oe   <= 1'b0;
			op_ready <= 1'b1;
			done     <= 1'b0;
			rd_data  <= 8'h00;
			ack_seen <= 1'b0;
		end
		else
		begin
			done <= 1'b0;
			if (accept)
			begin
				op_ready <= 1'b0;
				q        <= 2'h0;
				bidx     <= 4'h0;
				sh       <= op_data;
				is_rd    <= (op_code == rtcsl_pkg::RTCSL_OP_READ);
				nack_r   <= op_nack;
				unique case (op_code)
					rtcsl_pkg::RTCSL_OP_START: state <= rtcsl_pkg::RTCSL_M_START;
					rtcsl_pkg::RTCSL_OP_STOP:  state <= rtcsl_pkg::RTCSL_M_STOP;
					rtcsl_pkg::RTCSL_OP_WRITE: state <= rtcsl_pkg::RTCSL_M_BYTE;
					rtcsl_pkg::RTCSL_OP_READ:  state <= rtcsl_pkg::RTCSL_M_BYTE;
				endcase
			end
			else if (tick)
			begin
				q <= q + 2'h1;
				unique case (state)
					rtcsl_pkg::RTCSL_M_START:
						unique case (q)
							2'h0: sda_oe <= 1'b0;   // release for repeated start
							2'h1: scl_oe <= 1'b0;
							2'h2: sda_oe <= 1'b1;
							2'h3: scl_oe <= 1'b1;
						endcase
					rtcsl_pkg::RTCSL_M_STOP:
						unique case (q)
							2'h0: sda_oe <= 1'b1;
							2'h1: scl_oe <= 1'b0;
							2'h2: sda_oe <= 1'b0;
							2'h3: scl_oe <= 1'b0;
						endcase
					rtcsl_pkg::RTCSL_M_BYTE:
						unique case (q)
							2'h0: sda_oe <= !bit_out;
							2'h1: scl_oe <= 1'b0;
							2'h2:
								if (is_ack)
									ack_seen <= !sda_in;
								else
									sh <= {sh[6:0], sda_in};
							2'h3:
							begin
								scl_oe <= 1'b1;
								bidx   <= bidx + 4'h1;
							end
						endcase
					rtcsl_pkg::RTCSL_M_IDLE: q <= 2'h0;
				endcase
				if (last_q && (state != rtcsl_pkg::RTCSL_M_BYTE || is_ack))
				begin
					state    <= rtcsl_pkg::RTCSL_M_IDLE;
					op_ready <= 1'b1;
					done     <= 1'b1;
					rd_data  <= sh;
				end
			end
		end
	end
endmodule : rtcsl_master

// ---- verif/rtcsl_checker.sv ----
// wire-level checks of the two-wire link between master and rtc port
`timescale 1ns/1ps
module rtcsl_checker (
	input wire logic sys_clk,  // system clock
	input wire logic reset_n,  // async reset, low
	input wire logic scl_line, // resolved scl
	input wire logic sda_line, // resolved sda
	input wire logic sda_s_oe  // device pulls sda
);
	logic       scl_q;
	logic       sda_q;
	logic       busy;
	logic [5:0] cnt;
	logic [7:0] sh;
	logic [7:0] adr;

	// edge and condition decode; cond is a start (sda low) or stop (sda high)
	wire        rise     = scl_line && !scl_q;
	wire        cond     = scl_line && scl_q && (sda_line != sda_q);
	wire        ackr     = rise && (cnt % 9 == 8);
	wire        idle_bus = scl_line && sda_line;

	// scl rises since the last condition, and the first byte of the frame
	always_ff @(posedge sys_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			{scl_q, sda_q} <= 2'h3;
			busy           <= 1'b0;
			cnt            <= 6'h00;
			sh             <= 8'h00;
			adr            <= 8'h00;
		end
		else
		begin
			{scl_q, sda_q} <= {scl_line, sda_line};
			if (cond)
				busy <= !sda_line;
			if (cond)
				cnt <= 6'h00;
			else if (rise)
				cnt <= cnt + 6'h01;
			if (rise)
				sh <= {sh[6:0], sda_line};
			if (ackr && cnt == 6'h08)
				adr <= sh;
		end
	end

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!reset_n);

	a_dev_edge_low: assert property ($changed(sda_s_oe) |-> !scl_line && !scl_q)
		else $error("device sda moved while scl high");
	a_ack_hold: assert property (rise && sda_s_oe |-> sda_s_oe [*8])
		else $error("device let sda go during scl high");
	a_start_idle: assert property (cond && !sda_line |-> $past(idle_bus, 100))
		else $error("start without idle bus");
	a_start_free: assert property (cond && !sda_line |-> !sda_s_oe)
		else $error("device pulled sda at start");
	a_stop_quiet: assert property (cond && sda_line |=> !sda_s_oe [*8])
		else $error("device drove sda after stop");
	a_pulse_count: assert property (cond && busy |-> cnt % 9 == 1)
		else $error("frame not whole bytes of nine pulses");
	a_addr_ack: assert property (ackr && cnt == 6'h08 |-> sda_s_oe == (sh[7:1] == 7'h68))
		else $error("address acknowledge wrong");
	a_write_ack: assert property (ackr && cnt > 6'h08 && adr == 8'hD0 |-> sda_s_oe)
		else $error("received byte not acknowledged");
	a_read_free: assert property (ackr && cnt > 6'h08 && adr == 8'hD1 |-> !sda_s_oe)
		else $error("device held sda in master ack slot");
endmodule : rtcsl_checker

// ---- verif/test_rtc_i2c_slave_access_port.sv ----
// self-checking bench: bus master and rtc port face each other
`timescale 1ns/1ps
module test_rtc_i2c_slave_access_port;
	logic                 sys_clk;
	logic                 reset_n;
	logic                 op_valid;
	rtcsl_pkg::rtcsl_op_t op_code;
	logic           [7:0] op_data;
	logic                 op_nack;
	logic                 op_ready;
	logic                 done;
	logic           [7:0] rd_data;
	logic                 ack_seen;
	logic                 power_fail;
	logic                 tick_valid;
	logic          [55:0] tick_counts;
	logic                 copy_frozen;
	logic                 wr_strobe;
	logic           [2:0] wr_addr;
	logic           [7:0] wr_data;
	logic                 divider_reset;
	logic                 write_protect;
	logic           [7:0] cal_value;
	int                   miscompares;
	int                   n_checks;
	int                   cyc;
	int                   regs[8];
	int                   ptr;
	int                   we;
	int                   wq[$];

	rtcsl_if i_rtcsl_if ();
	rtcsl_master i_rtcsl_master (.sys_clk(sys_clk), .reset_n(reset_n),
		.bus(i_rtcsl_if.master), .op_valid(op_valid), .op_code(op_code),
		.op_data(op_data), .op_nack(op_nack), .op_ready(op_ready), .done(done),
		.rd_data(rd_data), .ack_seen(ack_seen));
	rtcsl_device i_rtcsl_device (.sys_clk(sys_clk), .reset_n(reset_n),
		.bus(i_rtcsl_if.device), .power_fail(power_fail), .tick_valid(tick_valid),
		.tick_counts(tick_counts), .copy_frozen(copy_frozen), .wr_strobe(wr_strobe),
		.wr_addr(wr_addr), .wr_data(wr_data), .divider_reset(divider_reset),
		.write_protect(write_protect), .cal_value(cal_value));
	rtcsl_checker i_rtcsl_checker (.sys_clk(sys_clk), .reset_n(reset_n),
		.scl_line(i_rtcsl_if.scl_line), .sda_line(i_rtcsl_if.sda_line),
		.sda_s_oe(i_rtcsl_if.sda_s_oe));

	task automatic close_out();
		$display("checks %0d mismatches %0d", n_checks, miscompares);
		if (miscompares == 0 && n_checks > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : close_out

	// flags are widened so one compare serves every result
	task automatic chk8(input string n, input int e, input logic [7:0] g);
		n_checks++;
		if (g !== e[7:0])
		begin
			miscompares++;
			$display("unexpected %s: expected %h seen %h", n, e[7:0], g);
		end
	endtask : chk8

	task automatic idle(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : idle

	// one master operation; the master is idle here, so it is taken at once
	task automatic op(input rtcsl_pkg::rtcsl_op_t c, input logic [7:0] d, input logic k);
		int w;
		op_code  = c;
		op_data  = d;
		op_nack  = k;
		op_valid = 1'b1;
		idle(1);
		op_valid = 1'b0;
		chk8("op_ready", 0, 8'(op_ready));
		for (w = 0; w < 6000 && done !== 1'b1; w++)
			idle(1);
		chk8("done", 1, 8'(done));
		chk8("op_ready", 1, 8'(op_ready));
	endtask : op

	task automatic bus_cond(input logic go);
		op(go ? rtcsl_pkg::RTCSL_OP_START : rtcsl_pkg::RTCSL_OP_STOP, 8'h00, 1'b0);
	endtask : bus_cond

	task automatic wb(input logic [7:0] d, input logic a);
		op(rtcsl_pkg::RTCSL_OP_WRITE, d, 1'b0);
		chk8("ack_seen", a, 8'(ack_seen));
	endtask : wb

	// model store: byte at the pointer, pointer wraps over eight places
	task automatic wd(input logic [7:0] d);
		regs[ptr] = d;
		wq.push_back(ptr * 256 + d);
		ptr = (ptr + 1) % 8;
		wb(d, 1'b1);
	endtask : wd

	task automatic rb(input logic k);
		int e;
		e = regs[ptr];
		ptr = (ptr + 1) % 8;
		op(rtcsl_pkg::RTCSL_OP_READ, 8'h00, k);
		chk8("rd_data", e, rd_data);
	endtask : rb

	// counter update; a frozen copy leaves the model untouched
	task automatic tick(input logic frz);
		int i;
		tick_counts = {$urandom(), 24'($urandom())};
		tick_valid  = 1'b1;
		idle(1);
		tick_valid = 1'b0;
		for (i = 0; i < 7; i++)
			if (!frz)
				regs[i] = tick_counts[8 * i +: 8];
	endtask : tick

	task automatic wait_wp();
		int w;
		for (w = 0; w < 400 && write_protect !== 1'b0; w++)
			idle(1);
		chk8("write_protect", 0, 8'(write_protect));
	endtask : wait_wp

	initial
	begin
		sys_clk = 1'b0;
		forever
			#2 sys_clk = !sys_clk;
	end

	// each stored byte must be the next one the model expects; looked at mid-cycle when settled
	always @(negedge sys_clk)
		if (wr_strobe === 1'b1)
		begin
			chk8("wr_pending", 1, 8'(wq.size() != 0));
			we = (wq.size() > 0) ? wq.pop_front() : -1;
			chk8("wr_addr", we / 256, 8'(wr_addr));
			chk8("wr_data", we % 256, wr_data);
			chk8("divider_reset", we / 256 != 7, 8'(divider_reset));
		end

	// hang guard: the sequence needs about 87000 cycles
	always @(posedge sys_clk)
	begin
		cyc++;
		if (cyc == 95000)
		begin
			miscompares++;
			close_out();
		end
	end

	initial
	begin
		{reset_n, op_valid, op_nack, power_fail, tick_valid} = 5'h00;
		op_code     = rtcsl_pkg::RTCSL_OP_START;
		op_data     = 8'h00;
		tick_counts = 56'h0;
		void'($urandom(76));
		idle(20);
		reset_n = 1'b1;
		wait_wp();
		tick(1'b0);
		bus_cond(1'b1);
		wb(8'hD0, 1'b1);
		wb(8'h06, 1'b1);
		ptr = 6;
		wd(8'($urandom()));
		wd(8'($urandom()));
		bus_cond(1'b0);
		chk8("cal_value", regs[7], cal_value);
		$display("test sequential write done");
		bus_cond(1'b1);
		wb(8'hD0, 1'b1);
		wb(8'h06, 1'b1);
		ptr = 6;
		chk8("copy_frozen", 1, 8'(copy_frozen));
		tick(1'b1);
		bus_cond(1'b1);
		wb(8'hD1, 1'b1);
		rb(1'b0);
		rb(1'b0);
		rb(1'b1);
		bus_cond(1'b0);
		chk8("copy_frozen", 0, 8'(copy_frozen));
		$display("test random read done");
		bus_cond(1'b1);
		wb(8'hD0, 1'b1);
		power_fail = 1'b1;
		idle(20);
		chk8("write_protect", 1, 8'(write_protect));
		power_fail = 1'b0;
		idle(200);
		chk8("write_protect", 1, 8'(write_protect));
		wait_wp();
		bus_cond(1'b0);
		ptr = 0;
		$display("test power fail done");
		bus_cond(1'b1);
		wb(8'hD2, 1'b0);
		bus_cond(1'b0);
		$display("test foreign address done");
		bus_cond(1'b1);
		wb(8'hD1, 1'b1);
		rb(1'b1);
		bus_cond(1'b0);
		$display("test current read done");
		chk8("wr_left", 0, 8'(wq.size()));
		close_out();
	end
endmodule : test_rtc_i2c_slave_access_port
